// ---- common/bsc_pkg.sv ----
package bsc_pkg;
  // Brake mode selector encodings
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_CONF = 4'h7;
  localparam logic [3:0] MODE_NOCONF = 4'h8;
  // Overspeed threshold value that switches the check off
  localparam logic [13:0] OVS_OFF = 14'h270F;
  // Timing base
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_NS = 1000000;
  localparam int TICK_CYC = MS_NS / CLK_PERIOD_NS;
  localparam int SUPERV_TMO_S = 2;
  localparam logic [12:0] SUPERV_TMO_MS = 13'(SUPERV_TMO_S * 1000);
  localparam logic [12:0] TMR_MAX = 13'h1FFF;
  // Fault vector bit positions
  localparam int F_OVS = 0;
  localparam int F_DEC = 1;
  localparam int F_GRV = 2;
  localparam int F_RTO = 3;
  localparam int F_CTO = 4;
  localparam int F_LOST = 5;
  localparam int F_ENG = 6;
  localparam int NFLT = 7;
  // Synchronised pin bit positions
  localparam int P_FWD = 0;
  localparam int P_REV = 1;
  localparam int P_JOG = 2;
  localparam int P_SFS = 3;
  localparam int P_CONF = 4;
  localparam int NPIN = 5;
  localparam logic [NPIN-1:0] PIN_RST = 5'h00;
  localparam logic [NFLT-1:0] FLT_RST = 7'h00;

  typedef enum logic [2:0] {
    BSC_IDLE = 3'h0,
    BSC_WAIT_CUR = 3'h1,
    BSC_WAIT_CONF = 3'h3,
    BSC_START_HOLD = 3'h2,
    BSC_RUN = 3'h6,
    BSC_WAIT_ENG = 3'h7,
    BSC_STOP_HOLD = 3'h5,
    BSC_FAULT = 3'h4
  } bsc_state_t;
endpackage

// ---- hdl/bsc_tick.sv ----
`timescale 1ns/100ps
module bsc_tick import bsc_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input wire logic sys_clk,
  input wire logic srst,
  output logic tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } bsc_tick_st_t;

  bsc_tick_st_t q_r, q_nxt;

  always_comb begin
    q_nxt = q_r;
    q_nxt.tick = 1'b0;
    if (q_r.cnt == 16'(TICK_CYCLES - 1)) begin
      q_nxt.cnt = 16'h0000;
      q_nxt.tick = 1'b1;
    end else begin
      q_nxt.cnt = q_r.cnt + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign tick = q_r.tick;
endmodule // bsc_tick

// ---- hdl/bsc_brake_seq.sv ----
`timescale 1ns/100ps
// Operation
// (RL1) Mode 0 normal, 7 sequencing with confirm, 8 sequencing without confirm.
// (RL2) Configuring party should prefer mode 7 for fuller control.
// (RL3) Jog or second-function at stop falls back to normal operation.
// (RL4) Once a sequence starts, jog and second-function are ignored until it ends.
// (RL5) Release speed 0..900 r/min, valid only when not above engage speed.
// (RL6) Release current 0..200 percent of rated current.
// (RL7) Release current detect time 0..2 s.
// (RL8) Start hold delay 0..5 s.
// (RL9) Stop hold delay 0..5 s.
// (RL10) Engage speed 0..900 r/min, valid only when not below release speed.
// (RL11) Decel check selector 1 faults on abnormal deceleration; 0 disables.
// (RL12) Abnormal decel check suppressed during stall prevention.
// (RL13) Vector control overspeed: detected minus output above threshold; 9999 disables.
// (RL14) Any fault: alarm, output off, release request off.
// (RL15) Release request while motor at stop raises gravity-drop fault.
// (RL16) No release request 2 s after run command raises a fault.
// (RL17) Confirm must follow request within 2 s, else timeout fault.
// (RL18) Confirm dropping while request held raises confirm-lost fault.
// (RL19) Confirm must clear within 2 s of request release, else fault.
// (RL20) Confirm input used only in mode 7.
// (RL21) Acceleration and deceleration times should be 1 s or longer.
// (RL22) Speed control must be selected before sequencing.
// (RL23) Request after detect time once speed and current reach release thresholds.
// (RL24) After confirm and start hold delay, ramp speed command to set speed.
// (RL25) Release request off at engage speed; output off after stop hold delay.
// (RL26) Mode 8 times hold delays from the request edge instead of confirm.
// (RL27) All delays and timeouts count millisecond ticks from a prescaler.
// (RL28) Faults stay latched with output and request off until fault reset.
module bsc_brake_seq import bsc_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic run_fwd,
  input wire logic run_rev,
  input wire logic jog_in,
  input wire logic second_function_select,
  input wire logic brake_release_confirm,
  input wire logic [3:0] brake_mode_select,
  input wire logic [9:0] release_speed_threshold,
  input wire logic [7:0] release_current_threshold,
  input wire logic [10:0] release_current_detect_time,
  input wire logic [12:0] start_hold_delay,
  input wire logic [9:0] engage_speed_threshold,
  input wire logic [12:0] stop_hold_delay,
  input wire logic decel_check_select,
  input wire logic [13:0] overspeed_threshold,
  input wire logic vector_control_active,
  input wire logic stall_prevent_active,
  input wire logic decel_abnormal,
  input wire logic motor_at_stop,
  input wire logic [9:0] speed_command,
  input wire logic [13:0] detected_speed,
  input wire logic [13:0] output_speed,
  input wire logic [7:0] output_current,
  input wire logic fault_reset,
  output logic brake_release_request,
  output logic output_enable,
  output logic speed_hold,
  output logic ramp_release,
  output logic normal_mode,
  output logic sequence_active,
  output logic alarm,
  output logic overspeed_fault,
  output logic abnormal_decel_fault,
  output logic gravity_drop_fault,
  output logic release_request_timeout_fault,
  output logic confirm_timeout_fault,
  output logic confirm_lost_fault,
  output logic engage_timeout_fault
);
  typedef struct packed {
    bsc_state_t st;
    logic [NPIN-1:0] s1;
    logic [NPIN-1:0] s2;
    logic [12:0] tmr;
    logic [10:0] det;
    logic req;
    logic oen;
    logic hold;
    logic ramp;
    logic normal;
    logic [NFLT-1:0] flt;
    logic alm;
    logic seq;
  } bsc_st_t;

  bsc_st_t q_r, q_nxt;
  logic tick;
  logic run, conf_used, seq_mode, ovs_hit, cur_ok;
  logic [NFLT-1:0] raise;

  bsc_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .sys_clk(sys_clk),
    .srst(srst),
    .tick(tick)
  ); // RL27

  always_comb begin
    q_nxt = q_r;
    raise = FLT_RST;
    // Pins pass two flops; only the second stage is read below
    q_nxt.s1 = {brake_release_confirm, second_function_select, jog_in, run_rev, run_fwd};
    q_nxt.s2 = q_r.s1;
    run = q_r.s2[P_FWD] | q_r.s2[P_REV];
    conf_used = (brake_mode_select == MODE_CONF); // RL20
    // Mismatched speed thresholds leave sequencing off rather than guessing
    seq_mode = ((brake_mode_select == MODE_CONF) || (brake_mode_select == MODE_NOCONF))
      && (release_speed_threshold <= engage_speed_threshold); // RL1 RL5 RL10
    // Only positive slip is checked, so the difference below can never wrap
    ovs_hit = vector_control_active && (overspeed_threshold != OVS_OFF)
      && (detected_speed > output_speed)
      && ((detected_speed - output_speed) > overspeed_threshold); // RL13
    cur_ok = (speed_command >= release_speed_threshold)
      && (output_current >= release_current_threshold); // RL6
    if (tick && (q_r.tmr != TMR_MAX)) begin
      q_nxt.tmr = q_r.tmr + 13'h0001; // RL27
    end
    case (q_r.st)
      BSC_IDLE: begin
        q_nxt.req = 1'b0;
        q_nxt.hold = 1'b0;
        q_nxt.ramp = 1'b0;
        if (!seq_mode || q_r.s2[P_JOG] || q_r.s2[P_SFS]) begin // RL4
          q_nxt.normal = 1'b1; // RL3
          q_nxt.oen = run;
        end else if (run && !q_r.oen) begin
          q_nxt.normal = 1'b0;
          q_nxt.oen = 1'b1;
          q_nxt.hold = 1'b1;
          q_nxt.st = BSC_WAIT_CUR;
          q_nxt.tmr = 13'h0000;
          q_nxt.det = 11'h000;
        end else begin
          // A normal run still going keeps its output until the run drops
          q_nxt.normal = q_r.oen;
          q_nxt.oen = q_r.oen & run;
        end
      end
      BSC_WAIT_CUR: begin
        if (!run) begin
          q_nxt.oen = 1'b0;
          q_nxt.hold = 1'b0;
          q_nxt.st = BSC_IDLE;
        end else if (q_r.tmr >= SUPERV_TMO_MS) begin
          raise[F_RTO] = 1'b1; // RL16
        end else if (cur_ok) begin
          if (q_r.det >= release_current_detect_time) begin
            q_nxt.req = 1'b1; // RL23 RL7
            q_nxt.tmr = 13'h0000;
            q_nxt.st = conf_used ? BSC_WAIT_CONF : BSC_START_HOLD; // RL26
            if (motor_at_stop) begin
              raise[F_GRV] = 1'b1; // RL15
            end
          end else if (tick) begin
            q_nxt.det = q_r.det + 11'h001;
          end
        end else begin
          q_nxt.det = 11'h000;
        end
      end
      BSC_WAIT_CONF: begin
        if (q_r.s2[P_CONF]) begin
          q_nxt.st = BSC_START_HOLD;
          q_nxt.tmr = 13'h0000;
        end else if (q_r.tmr >= SUPERV_TMO_MS) begin
          raise[F_CTO] = 1'b1; // RL17
        end
      end
      BSC_START_HOLD: begin
        if (conf_used && !q_r.s2[P_CONF]) begin
          raise[F_LOST] = 1'b1; // RL18
        end else if (q_r.tmr >= start_hold_delay) begin
          q_nxt.hold = 1'b0; // RL8 RL24
          q_nxt.ramp = 1'b1;
          q_nxt.st = BSC_RUN;
        end
      end
      BSC_RUN: begin
        if (conf_used && !q_r.s2[P_CONF]) begin
          raise[F_LOST] = 1'b1; // RL18
        end else if (!run) begin
          if (decel_check_select && !stall_prevent_active && decel_abnormal) begin
            raise[F_DEC] = 1'b1; // RL11 RL12
          end else if (detected_speed <= 14'(engage_speed_threshold)) begin
            q_nxt.req = 1'b0; // RL25
            q_nxt.ramp = 1'b0;
            q_nxt.tmr = 13'h0000;
            q_nxt.st = conf_used ? BSC_WAIT_ENG : BSC_STOP_HOLD; // RL26
          end
        end
      end
      BSC_WAIT_ENG: begin
        if (!q_r.s2[P_CONF]) begin
          q_nxt.st = BSC_STOP_HOLD;
          q_nxt.tmr = 13'h0000;
        end else if (q_r.tmr >= SUPERV_TMO_MS) begin
          raise[F_ENG] = 1'b1; // RL19
        end
      end
      BSC_STOP_HOLD: begin
        if (q_r.tmr >= stop_hold_delay) begin
          q_nxt.oen = 1'b0; // RL9 RL25
          q_nxt.st = BSC_IDLE;
        end
      end
      BSC_FAULT: begin
        q_nxt.req = 1'b0;
        q_nxt.oen = 1'b0;
        if (fault_reset) begin
          q_nxt.flt = FLT_RST; // RL28
          q_nxt.st = BSC_IDLE;
        end
      end
      default: begin
        q_nxt.st = BSC_FAULT;
        q_nxt.req = 1'b0;
        q_nxt.oen = 1'b0;
      end
    endcase
    if ((q_r.st != BSC_IDLE) && (q_r.st != BSC_FAULT) && ovs_hit) begin
      raise[F_OVS] = 1'b1; // RL13
    end
    if (|raise) begin
      q_nxt.flt = q_r.flt | raise; // RL14
      q_nxt.st = BSC_FAULT;
      q_nxt.req = 1'b0;
      q_nxt.oen = 1'b0;
      q_nxt.hold = 1'b0;
      q_nxt.ramp = 1'b0;
    end
    // Status decoded ahead of the register so both outputs leave straight from flops
    q_nxt.alm = (q_nxt.st == BSC_FAULT);
    q_nxt.seq = (q_nxt.st != BSC_IDLE) && (q_nxt.st != BSC_FAULT);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      q_r.st <= BSC_IDLE;
      q_r.s1 <= PIN_RST;
      q_r.s2 <= PIN_RST;
      q_r.tmr <= 13'h0000;
      q_r.det <= 11'h000;
      q_r.req <= 1'b0;
      q_r.oen <= 1'b0;
      q_r.hold <= 1'b0;
      q_r.ramp <= 1'b0;
      q_r.normal <= 1'b1;
      q_r.flt <= FLT_RST;
      q_r.alm <= 1'b0;
      q_r.seq <= 1'b0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Each output is a flop or a flop field; no gating after the register
  assign brake_release_request = q_r.req;
  assign output_enable = q_r.oen;
  assign speed_hold = q_r.hold;
  assign ramp_release = q_r.ramp;
  assign normal_mode = q_r.normal;
  assign overspeed_fault = q_r.flt[F_OVS];
  assign abnormal_decel_fault = q_r.flt[F_DEC];
  assign gravity_drop_fault = q_r.flt[F_GRV];
  assign release_request_timeout_fault = q_r.flt[F_RTO];
  assign confirm_timeout_fault = q_r.flt[F_CTO];
  assign confirm_lost_fault = q_r.flt[F_LOST];
  assign engage_timeout_fault = q_r.flt[F_ENG];
  assign alarm = q_r.alm;
  assign sequence_active = q_r.seq;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_release;
    $rose(q_r.req);
  endsequence

  sequence s_engage;
    $fell(q_r.req) && (q_r.st != BSC_FAULT);
  endsequence

  sequence s_output_off;
    $fell(q_r.oen) && !alarm && ($past(q_r.st) == BSC_STOP_HOLD);
  endsequence

  fault_output_off_a: assert property (alarm |-> !q_r.req && !q_r.oen) // RL14
    else $error("output or request on during alarm");
  fault_latched_a: assert property (alarm && !fault_reset |=> alarm && $stable(q_r.flt)) // RL28
    else $error("fault cleared without reset");
  no_jog_seq_a: assert property (sequence_active |-> !q_r.normal) // RL4
    else $error("normal mode taken during sequence");
  confirm_mode_a: assert property ($rose(q_r.flt[F_CTO]) || $rose(q_r.flt[F_ENG]) // RL20
    |-> $past(brake_mode_select) == MODE_CONF)
    else $error("confirm fault outside mode 7");
  confirm_tmo_a: assert property ($rose(q_r.flt[F_CTO]) |-> $past(q_r.tmr) >= SUPERV_TMO_MS) // RL17
    else $error("confirm timeout too early");
  run_tmo_a: assert property ($rose(q_r.flt[F_RTO]) // RL16
    |-> $past(q_r.tmr) >= SUPERV_TMO_MS && $past(q_r.st) == BSC_WAIT_CUR)
    else $error("request timeout wrong");
  ovs_off_a: assert property ($rose(q_r.flt[F_OVS]) // RL13
    |-> $past(overspeed_threshold) != OVS_OFF && $past(vector_control_active))
    else $error("overspeed raised while disabled");
  decel_sel_a: assert property ($rose(q_r.flt[F_DEC]) // RL11
    |-> $past(decel_check_select) && !$past(stall_prevent_active))
    else $error("decel fault while disabled");
  release_det_a: assert property (s_release // RL23
    |-> $past(q_r.det) >= $past(release_current_detect_time) && $past(q_r.st) == BSC_WAIT_CUR)
    else $error("release before detect time");
  engage_ramp_a: assert property (s_engage // RL25
    |-> !q_r.ramp && q_r.oen ##1 (q_r.oen || alarm || (stop_hold_delay == 13'h0000)))
    else $error("engage step wrong");
  decel_run_a: assert property ($rose(q_r.flt[F_DEC]) // RL11
    |-> $past(q_r.st) == BSC_RUN && !$past(run))
    else $error("decel fault outside stopping run");
  gravity_drop_a: assert property ($rose(q_r.flt[F_GRV]) // RL15
    |-> $past(motor_at_stop) && $past(q_r.st) == BSC_WAIT_CUR)
    else $error("gravity fault without release at stop");
  confirm_lost_a: assert property ($rose(q_r.flt[F_LOST]) // RL18
    |-> $past(brake_mode_select) == MODE_CONF && !$past(q_r.s2[P_CONF]))
    else $error("confirm lost raised while confirm held");
  engage_tmo_a: assert property ($rose(q_r.flt[F_ENG]) // RL19
    |-> $past(q_r.tmr) >= SUPERV_TMO_MS && $past(q_r.st) == BSC_WAIT_ENG)
    else $error("engage timeout wrong");
  start_hold_a: assert property ($rose(q_r.ramp) // RL8 RL24
    |-> $past(q_r.tmr) >= $past(start_hold_delay) && $past(q_r.st) == BSC_START_HOLD)
    else $error("ramp released before start hold");
  stop_hold_a: assert property (s_output_off |-> $past(q_r.tmr) >= $past(stop_hold_delay)) // RL9
    else $error("output off before stop hold");
  release_path_a: assert property (s_release // RL26
    |-> q_r.st == (($past(brake_mode_select) == MODE_CONF) ? BSC_WAIT_CONF : BSC_START_HOLD))
    else $error("release went to wrong hold state");
  release_cur_a: assert property (s_release |-> $past(cur_ok)) // RL6
    else $error("release without speed and current");
  jog_fallback_a: assert property (!sequence_active && !alarm && (q_r.s2[P_JOG] || q_r.s2[P_SFS]) // RL3
    |=> q_r.normal)
    else $error("jog at stop did not fall back");
  hold_output_a: assert property (q_r.hold |-> q_r.oen && !q_r.ramp) // RL24
    else $error("speed hold without output");
  ramp_release_a: assert property (q_r.ramp |-> q_r.req && q_r.oen) // RL24
    else $error("ramp without release request");
  request_output_a: assert property (q_r.req |-> q_r.oen) // RL25
    else $error("release request without output");
  idle_quiet_a: assert property (!sequence_active && !alarm |-> !q_r.req && !q_r.hold && !q_r.ramp) // RL25
    else $error("idle with sequence outputs on");
endmodule // bsc_brake_seq

// ---- tb/bsc_brake_model.sv ----
`timescale 1ns/100ps
module bsc_brake_model #(
  parameter int LAG = 20
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic brake_release_request,
  input wire logic [1:0] fail_mode,
  output logic brake_release_confirm
);
  // Fault kinds: 1 never releases, 2 drops confirm while held, 3 sticks released
  logic [7:0] cnt_r;
  logic tgt;
  assign tgt = (fail_mode == 2'h1) ? 1'b0 :
    (fail_mode == 2'h3) ? (brake_release_confirm | brake_release_request) : brake_release_request;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      brake_release_confirm <= 1'b0;
      cnt_r <= 8'h00;
    end else if (fail_mode == 2'h2 && brake_release_confirm && brake_release_request) begin
      cnt_r <= cnt_r + 8'h01;
      if (cnt_r == 8'h3C) begin
        brake_release_confirm <= 1'b0;
        cnt_r <= 8'h00;
      end
    end else if (tgt != brake_release_confirm) begin
      // Mechanical lag, far inside the supervision windows
      cnt_r <= cnt_r + 8'h01;
      if (cnt_r == 8'(LAG)) begin
        brake_release_confirm <= tgt;
        cnt_r <= 8'h00;
      end
    end else begin
      cnt_r <= 8'h00;
    end
  end
endmodule // bsc_brake_model

// ---- tb/tb.sv ----
`timescale 1ns/100ps
module tb import bsc_pkg::*;;
  localparam int REQ = 0, OE = 1, RR = 3, AL = 6;
  logic sys_clk = 1'b0, srst = 1'b1, run_fwd = 1'b0, run_rev = 1'b0, jog_in = 1'b0, second_function_select = 1'b0;
  logic decel_check_select = 1'b0, vector_control_active = 1'b1, stall_prevent_active = 1'b0;
  logic decel_abnormal = 1'b0, motor_at_stop = 1'b0, fault_reset = 1'b0;
  logic [3:0] brake_mode_select = 4'h0;
  logic [9:0] release_speed_threshold = 10'h000, engage_speed_threshold = 10'h000, speed_command = 10'h000;
  logic [7:0] release_current_threshold = 8'h00, output_current = 8'h00;
  logic [10:0] release_current_detect_time = 11'h000;
  logic [12:0] start_hold_delay = 13'h0000, stop_hold_delay = 13'h0000;
  logic [13:0] overspeed_threshold = OVS_OFF, detected_speed = 14'h0000, output_speed = 14'h0000;
  logic [1:0] fail_mode = 2'h0;
  logic brake_release_confirm, brake_release_request, output_enable, speed_hold, ramp_release, normal_mode;
  logic sequence_active, alarm, overspeed_fault, abnormal_decel_fault, gravity_drop_fault;
  logic release_request_timeout_fault, confirm_timeout_fault, confirm_lost_fault, engage_timeout_fault;
  logic [6:0] obs, flt;
  logic [31:0] seed = 32'h8037;
  int num_errors = 0, checked = 0;
  assign obs = {alarm, sequence_active, normal_mode, ramp_release, speed_hold, output_enable, brake_release_request};
  assign flt = {engage_timeout_fault, confirm_lost_fault, confirm_timeout_fault, release_request_timeout_fault,
    gravity_drop_fault, abnormal_decel_fault, overspeed_fault};
  always #50 sys_clk = ~sys_clk;
  // Short tick keeps the 2 s timeouts at 8000 cycles
  bsc_brake_seq #(.TICK_CYCLES(4)) DUT (.sys_clk, .srst, .run_fwd, .run_rev, .jog_in, .second_function_select,
    .brake_release_confirm, .brake_mode_select, .release_speed_threshold, .release_current_threshold,
    .release_current_detect_time, .start_hold_delay, .engage_speed_threshold, .stop_hold_delay,
    .decel_check_select, .overspeed_threshold, .vector_control_active, .stall_prevent_active, .decel_abnormal,
    .motor_at_stop, .speed_command, .detected_speed, .output_speed, .output_current, .fault_reset,
    .brake_release_request, .output_enable, .speed_hold, .ramp_release, .normal_mode, .sequence_active, .alarm,
    .overspeed_fault, .abnormal_decel_fault, .gravity_drop_fault, .release_request_timeout_fault,
    .confirm_timeout_fault, .confirm_lost_fault, .engage_timeout_fault);
  bsc_brake_model #(.LAG(20)) brake (.sys_clk, .srst, .brake_release_request, .fail_mode, .brake_release_confirm);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] one_flt(int b);
    return 8'(7'h01 << b);
  endfunction
  task automatic report_and_stop();
    if (num_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wait_bit(input int k, input logic v, input int bound);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (obs[k] !== v && n < bound);
    if (obs[k] !== v) begin
      chk(8'(obs[k]), 8'(v));
      report_and_stop();
    end
  endtask
  task automatic start_run(input logic [3:0] m, input logic cur_ok);
    logic [9:0] r;
    logic [7:0] c;
    r = 10'(rnd() % 100 + 10);
    c = 8'(rnd() % 90 + 50);
    @(posedge sys_clk);
    brake_mode_select <= m;
    release_speed_threshold <= r;
    engage_speed_threshold <= r + 10'h002;
    speed_command <= r + 10'h005;
    detected_speed <= 14'(r) + 14'h0005;
    release_current_threshold <= c;
    output_current <= cur_ok ? c + 8'(rnd() % 50) : c - 8'h01;
    release_current_detect_time <= 11'(rnd() % 8);
    start_hold_delay <= 13'(rnd() % 8 + 1);
    stop_hold_delay <= 13'(rnd() % 8 + 1);
    run_fwd <= 1'b1;
  endtask
  task automatic stop_run();
    @(posedge sys_clk);
    run_fwd <= 1'b0;
    detected_speed <= 14'(release_speed_threshold);
  endtask
  task automatic seq_pass(input logic [3:0] m);
    start_run(m, 1'b1);
    wait_bit(REQ, 1'b1, 2000);
    @(posedge sys_clk);
    jog_in <= 1'b1;
    second_function_select <= 1'b1;
    wait_bit(RR, 1'b1, 2000);
    chk(8'({sequence_active, speed_hold, alarm}), 8'h04);
    stop_run();
    wait_bit(REQ, 1'b0, 2000);
    chk(8'(output_enable), 8'h01);
    wait_bit(OE, 1'b0, 2000);
    chk({alarm, flt}, 8'h00);
    @(posedge sys_clk);
    jog_in <= 1'b0;
    second_function_select <= 1'b0;
  endtask
  task automatic expect_fault(input int b);
    wait_bit(AL, 1'b1, 12000);
    chk(8'(flt), one_flt(b));
    chk(8'({brake_release_request, output_enable}), 8'h00);
    @(posedge sys_clk);
    run_fwd <= 1'b0;
    fail_mode <= 2'h0;
    motor_at_stop <= 1'b0;
    overspeed_threshold <= OVS_OFF;
    decel_abnormal <= 1'b0;
    repeat (40) @(posedge sys_clk);
    #1 chk(8'({alarm, output_enable}), 8'h02);
    @(posedge sys_clk);
    fault_reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    fault_reset <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 chk({alarm, flt}, 8'h00);
    @(posedge sys_clk);
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 chk(8'(obs), 8'h10);
    seq_pass(MODE_CONF);
    fail_mode <= 2'h1;
    seq_pass(MODE_NOCONF);
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      brake_mode_select <= (i == 0) ? MODE_NORMAL : MODE_CONF;
      jog_in <= (i == 1);
      second_function_select <= (i == 2);
      run_fwd <= 1'b1;
      repeat (30) @(posedge sys_clk);
      #1 chk(8'({sequence_active, brake_release_request, normal_mode}), 8'h01);
      @(posedge sys_clk);
      run_fwd <= 1'b0;
      jog_in <= 1'b0;
      second_function_select <= 1'b0;
      repeat (10) @(posedge sys_clk);
    end
    fail_mode <= 2'h1;
    start_run(MODE_CONF, 1'b1);
    expect_fault(F_CTO);
    fail_mode <= 2'h2;
    start_run(MODE_CONF, 1'b1);
    expect_fault(F_LOST);
    start_run(MODE_CONF, 1'b0);
    expect_fault(F_RTO);
    motor_at_stop <= 1'b1;
    start_run(MODE_NOCONF, 1'b1);
    expect_fault(F_GRV);
    overspeed_threshold <= 14'h0005;
    start_run(MODE_CONF, 1'b1);
    expect_fault(F_OVS);
    start_run(MODE_CONF, 1'b1);
    wait_bit(RR, 1'b1, 2000);
    @(posedge sys_clk);
    {stall_prevent_active, decel_check_select, decel_abnormal, run_fwd} <= 4'hE;
    repeat (20) @(posedge sys_clk);
    #1 chk(8'(alarm), 8'h00);
    @(posedge sys_clk);
    stall_prevent_active <= 1'b0;
    expect_fault(F_DEC);
    fail_mode <= 2'h3;
    start_run(MODE_CONF, 1'b1);
    wait_bit(RR, 1'b1, 2000);
    stop_run();
    expect_fault(F_ENG);
    report_and_stop();
  end
endmodule // tb
